// ==== common/bmf_pkg.sv ====
// Shared constants and types of the bus-matching buffer
package bmf_pkg;
   // Storage organizations, in 36-bit words
   localparam int BMF_DEPTH_SMALL = 65536;
   localparam int BMF_DEPTH_LARGE = 131072;
   localparam int BMF_WORD_W      = 36;
   // Read clock edges before a word falls through
   localparam int BMF_FALL_THROUGH_MODE_EDGES  = 3;
   localparam int BMF_OFS_W       = 17;
   // Preset flag offsets, picked by {load, select1, select0}; values arbitrary
   localparam logic [16:0] BMF_PRESET [0:7] = '{
      17'h00007, 17'h0001f, 17'h0003f, 17'h0007f,
      17'h000ff, 17'h001ff, 17'h003ff, 17'h007ff};

   typedef enum logic [1:0] {BMF_W36, BMF_W18, BMF_W9} bmf_width_e;
   typedef enum logic [1:0] {BMF_OUT_EMPTY, BMF_OUT_WAIT, BMF_OUT_FETCH, BMF_OUT_HOLD} bmf_out_e;

   // Narrow words per 36-bit storage word, less one
   function automatic logic [1:0] bmf_last(input bmf_width_e w);
      case (w)
         BMF_W18: return 2'h1;
         BMF_W9:  return 2'h3;
         default: return 2'h0;
      endcase
   endfunction
endpackage

// ==== hdl/bmf_mem.sv ====
// Word storage with registered read data
`timescale 1ns/1ps
module bmf_mem #(
   parameter int AW = 16,
   parameter int DW = 36
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          resetn,
   // Write side
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read side
   input  wire logic          re,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] store [0:(2**AW)-1];

   // Array has no reset: too deep to clear, pointers hide stale words
   always_ff @(posedge mclk) begin
      if (we) begin
         store[waddr] <= wdata;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= store[raddr];
      end
   end
endmodule

// ==== hdl/bmf_pack.sv ====
// Packs narrow input words into 36-bit storage words
`timescale 1ns/1ps
module bmf_pack
   import bmf_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        clear,
   // Input words
   input  wire logic        ev,
   input  wire logic [35:0] din,
   input  wire bmf_width_e  width,
   input  wire logic        be,
   // Packed words
   output logic      [35:0] word,
   output logic             word_valid
);
   logic [35:0] acc;
   logic [35:0] next_acc;
   logic [1:0]  idx;
   logic [1:0]  last;
   logic [1:0]  pos;

   assign last = bmf_last(width);
   assign pos  = be ? last - idx : idx;

   always_comb begin
      next_acc = acc;
      case (width)
         BMF_W18: begin
            if (pos[0]) next_acc[35:18] = din[17:0];
            else        next_acc[17:0]  = din[17:0];
         end
         BMF_W9: begin
            case (pos)
               2'h0:    next_acc[8:0]   = din[8:0];
               2'h1:    next_acc[17:9]  = din[8:0];
               2'h2:    next_acc[26:18] = din[8:0];
               default: next_acc[35:27] = din[8:0];
            endcase
         end
         default: next_acc = din;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         acc        <= '0;
         idx        <= '0;
         word       <= '0;
         word_valid <= 1'b0;
      end else if (clear) begin
         idx        <= '0;
         word_valid <= 1'b0;
      end else begin
         word_valid <= 1'b0;
         if (ev) begin
            acc <= next_acc;
            if (idx == last) begin
               idx        <= '0;
               word       <= next_acc;
               word_valid <= 1'b1;
            end else begin
               idx <= idx + 2'h1;
            end
         end
      end
   end
endmodule

// ==== hdl/bmf_top.sv ====
// Bus-matching first-in first-out buffer, top level
`timescale 1ns/1ps
module bmf_top
   import bmf_pkg::*;
#(
   parameter int DEPTH = BMF_DEPTH_SMALL
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Reset pins
   input  wire logic        full_reset_n,
   input  wire logic        partial_reset_n,
   // Configuration pins, captured during full reset
   input  wire logic        input_width_select,
   input  wire logic        output_width_select,
   input  wire logic        width_match_select,
   input  wire logic        byte_order_select_n,
   input  wire logic        mode_or_serial_input_pin,
   input  wire logic        async_write_select,
   input  wire logic        async_read_select,
   input  wire logic        flag_sync_select,
   input  wire logic [1:0]  offset_select,
   // Offset loading
   input  wire logic        load_n,
   input  wire logic        serial_enable_n,
   // Write port
   input  wire logic        wclk,
   input  wire logic        wen_n,
   input  wire logic        write_strobe,
   input  wire logic [35:0] data_input_bus,
   // Read port
   input  wire logic        rclk,
   input  wire logic        ren_n,
   input  wire logic        read_strobe,
   input  wire logic        reread_request_n,
   input  wire logic        output_enable_n,
   output logic      [35:0] data_output_bus,
   output logic             data_output_oe,
   // Flags
   output logic             empty_or_ready_n,
   output logic             full_or_space_n,
   output logic             half_full_indicator_n,
   output logic             almost_empty_indicator_n,
   output logic             almost_full_indicator_n
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] HALF_C  = (AW+1)'(DEPTH / 2);
   localparam logic [1:0]  WAIT_LAST = 2'(BMF_FALL_THROUGH_MODE_EDGES - 1);

   // Configuration
   bmf_width_e in_w;
   bmf_width_e out_w;
   logic       be;
   logic       fall_through_mode;
   logic       async_w;
   logic       async_r;
   logic       flag_sync;
   logic [AW:0] ae_ofs;
   logic [AW:0] af_ofs;
   logic        par_sel;

   // Edge detection and events
   logic wclk_q;
   logic rclk_q;
   logic wstb_q;
   logic rstb_q;
   logic wclk_rise;
   logic rclk_rise;
   logic wr_ev;
   logic rd_ev;
   logic clr;

   // Data path
   logic [AW:0]   wptr;
   logic [AW:0]   rptr;
   logic [AW:0]   count;
   logic          full;
   logic          mem_avail;
   logic [35:0]   pk_word;
   logic          pk_valid;
   logic [35:0]   rdata;
   logic          fetch_go;
   bmf_out_e      state;
   logic [1:0]    idx;
   logic [1:0]    last;
   logic [1:0]    edge_cnt;
   logic [35:0]   hold;
   logic          std_empty;

   function automatic logic [1:0] pos_of(input logic [1:0] i);
      return be ? last - i : i;
   endfunction

   // Selects one narrow part of a storage word into the low bits
   function automatic logic [35:0] part_of(input logic [35:0] w, input logic [1:0] p);
      logic [35:0] r;
      r = '0;
      case (out_w)
         BMF_W18: r[17:0] = p[0] ? w[35:18] : w[17:0];
         BMF_W9: begin
            case (p)
               2'h0:    r[8:0] = w[8:0];
               2'h1:    r[8:0] = w[17:9];
               2'h2:    r[8:0] = w[26:18];
               default: r[8:0] = w[35:27];
            endcase
         end
         default: r = w;
      endcase
      return r;
   endfunction

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   assign clr = !full_reset_n || !partial_reset_n;

   // Pins are sampled; both port clocks may run at any rate below mclk/2
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wclk_q <= 1'b0;
         rclk_q <= 1'b0;
         wstb_q <= 1'b0;
         rstb_q <= 1'b0;
      end else begin
         wclk_q <= wclk;
         rclk_q <= rclk;
         wstb_q <= write_strobe;
         rstb_q <= read_strobe;
      end
   end

   assign wclk_rise = wclk && !wclk_q;
   assign rclk_rise = rclk && !rclk_q;
   // Asynchronous ports look at the strobe only
   assign wr_ev = async_w ? (write_strobe && !wstb_q) : (wclk_rise && !wen_n);
   assign rd_ev = async_r ? (read_strobe && !rstb_q) : (rclk_rise && !ren_n);

   // Mode capture while full reset is held
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         in_w      <= BMF_W36;
         out_w     <= BMF_W36;
         be        <= 1'b0;
         fall_through_mode      <= 1'b0;
         async_w   <= 1'b0;
         async_r   <= 1'b0;
         flag_sync <= 1'b0;
      end else if (!full_reset_n) begin
         in_w  <= BMF_W36;
         out_w <= BMF_W36;
         if (width_match_select) begin
            case ({input_width_select, output_width_select})
               2'b00:   out_w <= BMF_W18;
               2'b01:   out_w <= BMF_W9;
               2'b10:   in_w  <= BMF_W18;
               default: in_w  <= BMF_W9;
            endcase
         end
         be        <= !byte_order_select_n;
         // Fall-through is refused with an asynchronous read port
         fall_through_mode      <= mode_or_serial_input_pin && !async_read_select;
         async_w   <= async_write_select;
         async_r   <= async_read_select;
         flag_sync <= flag_sync_select;
      end
   end

   // Offsets: presets at full reset, kept over partial reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ae_ofs  <= '0;
         af_ofs  <= '0;
         par_sel <= 1'b0;
      end else if (!full_reset_n) begin
         ae_ofs  <= (AW+1)'(BMF_PRESET[{load_n, offset_select}]);
         af_ofs  <= (AW+1)'(BMF_PRESET[{load_n, offset_select}]);
         par_sel <= 1'b0;
      end else if (!load_n && wclk_rise && !serial_enable_n) begin
         {ae_ofs, af_ofs} <= {ae_ofs[AW-1:0], af_ofs, mode_or_serial_input_pin};
      end else if (!load_n && wclk_rise && !wen_n) begin
         // Parallel loads alternate: empty threshold, then full threshold
         if (par_sel) af_ofs <= data_input_bus[AW:0];
         else         ae_ofs <= data_input_bus[AW:0];
         par_sel <= !par_sel;
      end
   end

   assign count     = wptr - rptr;
   assign full      = count == DEPTH_C;
   assign mem_avail = count != '0;
   assign last      = bmf_last(out_w);

   bmf_pack u_pack (
      .mclk       (mclk),
      .resetn     (resetn),
      .clear      (clr),
      .ev         (wr_ev && load_n && !full),
      .din        (data_input_bus),
      .width      (in_w),
      .be         (be),
      .word       (pk_word),
      .word_valid (pk_valid)
   );

   bmf_mem #(.AW(AW), .DW(BMF_WORD_W)) u_mem (
      .mclk   (mclk),
      .resetn (resetn),
      .we     (pk_valid && !clr),
      .waddr  (wptr[AW-1:0]),
      .wdata  (pk_word),
      .re     (fetch_go),
      .raddr  (rptr[AW-1:0]),
      .rdata  (rdata)
   );

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wptr <= '0;
      end else if (clr) begin
         wptr <= '0;
      end else if (pk_valid) begin
         wptr <= wptr + 1'b1;
      end
   end

   a_write_stored: assert property (
      (wclk_rise && !wen_n && !async_w && load_n && !full && in_w == BMF_W36 && !clr)
      ##1 !clr[*2] |-> wptr == $past(wptr, 2) + 1'b1)
      else $error("synchronous write did not advance write pointer");

   a_strobe_write: assert property (
      (async_w && write_strobe && !wstb_q && load_n && !full && !clr) |=> pk_valid || in_w != BMF_W36)
      else $error("strobe write not taken");

   assign fetch_go = (state == BMF_OUT_EMPTY && !fall_through_mode && rd_ev && mem_avail)
                  || (state == BMF_OUT_WAIT && rclk_rise && edge_cnt == WAIT_LAST)
                  || (state == BMF_OUT_HOLD && rd_ev && idx == last && mem_avail);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rptr <= '0;
      end else if (clr) begin
         rptr <= '0;
      end else if (rclk_rise && !reread_request_n) begin
         rptr <= '0;
      end else if (fetch_go) begin
         rptr <= rptr + 1'b1;
      end
   end

   a_reread_start: assert property (
      (rclk_rise && !reread_request_n) |=> rptr == '0)
      else $error("reread did not return read pointer to start");

   // Output stage
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state    <= BMF_OUT_EMPTY;
         idx      <= '0;
         edge_cnt <= '0;
         hold     <= '0;
         data_output_bus <= '0;
      end else if (clr) begin
         state    <= BMF_OUT_EMPTY;
         idx      <= '0;
         edge_cnt <= '0;
         if (!full_reset_n) data_output_bus <= '0;
      end else begin
         case (state)
            BMF_OUT_EMPTY: begin
               edge_cnt <= '0;
               if (fetch_go) state <= BMF_OUT_FETCH;
               else if (fall_through_mode && mem_avail) state <= BMF_OUT_WAIT;
            end
            BMF_OUT_WAIT: begin
               if (fetch_go) state <= BMF_OUT_FETCH;
               else if (rclk_rise) edge_cnt <= edge_cnt + 2'h1;
            end
            BMF_OUT_FETCH: begin
               hold  <= rdata;
               idx   <= '0;
               state <= BMF_OUT_HOLD;
               data_output_bus <= part_of(rdata, pos_of(2'h0));
            end
            default: begin
               if (rd_ev) begin
                  if (idx != last) begin
                     idx <= idx + 2'h1;
                     data_output_bus <= part_of(hold, pos_of(idx + 2'h1));
                  end else if (fetch_go) begin
                     state <= BMF_OUT_FETCH;
                  end else begin
                     // Last word stays on the bus after it is taken
                     state <= BMF_OUT_EMPTY;
                  end
               end
            end
         endcase
      end
   end

   sequence s_fetch_shown;
      state == BMF_OUT_FETCH ##1 state == BMF_OUT_HOLD;
   endsequence

   a_read_delivers: assert property (
      (state == BMF_OUT_HOLD && rd_ev && idx == last && mem_avail && !clr) |=> s_fetch_shown)
      else $error("read with data waiting did not fetch a word");

   a_std_no_fall: assert property (
      (!fall_through_mode && state == BMF_OUT_EMPTY && !rd_ev) |=> state != BMF_OUT_FETCH)
      else $error("standard mode presented a word without a read");

   sequence s_three_rises;
      (state == BMF_OUT_WAIT && edge_cnt == WAIT_LAST && rclk_rise && !clr);
   endsequence

   a_fall_three: assert property (
      s_three_rises |=> s_fetch_shown)
      else $error("fall-through word not moved out on third read clock rise");

   a_async_std: assert property (
      async_r |-> !fall_through_mode)
      else $error("fall-through active with asynchronous read port");

   // Flags
   assign std_empty = !mem_avail && state != BMF_OUT_FETCH && !(state == BMF_OUT_HOLD && idx != last);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         empty_or_ready_n      <= 1'b0;
         full_or_space_n       <= 1'b1;
         half_full_indicator_n <= 1'b1;
         data_output_oe        <= 1'b0;
      end else begin
         // Fall-through: low means word ready / room to write
         empty_or_ready_n      <= fall_through_mode ? (state != BMF_OUT_HOLD) : !std_empty;
         full_or_space_n       <= fall_through_mode ? full : !full;
         half_full_indicator_n <= !(count > HALF_C);
         data_output_oe        <= !output_enable_n;
      end
   end

   // Synchronous almost flags move only on their own port's clock, or while a reset pin is low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         almost_empty_indicator_n <= 1'b0;
         almost_full_indicator_n  <= 1'b1;
      end else begin
         if (!flag_sync || rclk_rise || clr) begin
            almost_empty_indicator_n <= !(count <= ae_ofs);
         end
         if (!flag_sync || wclk_rise || clr) begin
            almost_full_indicator_n <= !(count >= DEPTH_C - af_ofs);
         end
      end
   end

   a_oe_gates_bus: assert property (
      output_enable_n |=> !data_output_oe)
      else $error("output driven while drive enable inactive");

   a_empty_flag: assert property (
      (!fall_through_mode && std_empty) |=> !empty_or_ready_n)
      else $error("empty flag not asserted in standard mode");

   a_half_full: assert property (
      (count > HALF_C) |=> !half_full_indicator_n)
      else $error("half full flag missed");

   a_partial_keeps: assert property (
      (!partial_reset_n && full_reset_n) |=> ae_ofs == $past(ae_ofs) && count == '0)
      else $error("partial reset lost offsets or kept data");
endmodule

// ==== sim/bmf_host_model.sv ====
// Writer and reader host logic on the far side of the buffer
`timescale 1ns/1ps
module bmf_host_model (
   // Clock
   input  wire logic        mclk,
   // Write side
   output logic             wclk,
   output logic             wen_n,
   output logic             write_strobe,
   output logic [35:0]      data_input_bus,
   // Read side
   output logic             rclk,
   output logic             ren_n,
   output logic             read_strobe,
   output logic             reread_request_n
);
   logic asyw = 1'b0;
   logic asyr = 1'b0;

   initial begin
      wclk = 1'b0;
      wen_n = 1'b1;
      write_strobe = 1'b0;
      data_input_bus = 36'h0;
      rclk = 1'b0;
      ren_n = 1'b1;
      read_strobe = 1'b0;
      reread_request_n = 1'b1;
   end

   // Strobe ports keep their enables low for good
   task automatic set_mode(input logic aw, input logic ar);
      asyw = aw;
      asyr = ar;
      wen_n = !aw;
      ren_n = !ar;
   endtask

   // Clocks stand still between transfers; released data shows its inverse
   task automatic wr(input logic [35:0] d);
      @(negedge mclk);
      data_input_bus = d;
      if (asyw) write_strobe = 1'b1;
      else begin
         wclk = 1'b1;
         wen_n = 1'b0;
      end
      repeat (2) @(negedge mclk);
      wclk = 1'b0;
      write_strobe = 1'b0;
      wen_n = !asyw;
      data_input_bus = ~d;
      @(negedge mclk);
   endtask

   // en: read request, rr: reread request, neither: bare clock rise
   task automatic rc(input logic en, input logic rr);
      @(negedge mclk);
      if (asyr && en) read_strobe = 1'b1;
      else begin
         rclk = 1'b1;
         ren_n = asyr ? 1'b0 : !en;
         reread_request_n = !rr;
      end
      repeat (2) @(negedge mclk);
      rclk = 1'b0;
      read_strobe = 1'b0;
      ren_n = !asyr;
      reread_request_n = 1'b1;
      @(negedge mclk);
   endtask
endmodule

// ==== sim/bmf_top_bench.sv ====
// Self-checking bench of the bus-matching buffer
`timescale 1ns/1ps
module bmf_top_bench;
   import bmf_pkg::*;
   localparam int DEP = 16;
   // Serial offsets: empty threshold 1, full threshold 2, empty shifted first
   localparam int OFS = $clog2(DEP) + 1;
   localparam logic [2*OFS-1:0] SER = {OFS'(1), OFS'(2)};
   logic        mclk, resetn, full_reset_n, partial_reset_n;
   logic        input_width_select, output_width_select, width_match_select, byte_order_select_n;
   logic        mode_or_serial_input_pin, async_write_select, async_read_select, flag_sync_select;
   logic [1:0]  offset_select;
   logic        load_n, serial_enable_n, output_enable_n;
   logic        wclk, wen_n, write_strobe, rclk, ren_n, read_strobe, reread_request_n;
   logic [35:0] data_input_bus, data_output_bus;
   logic        data_output_oe, empty_or_ready_n, full_or_space_n;
   logic        half_full_indicator_n, almost_empty_indicator_n, almost_full_indicator_n;
   logic [35:0] q[$];
   logic [35:0] d, e, h, w0, qo;
   int          n, ae_o, af_o, p, sw;
   int          fails = 0;
   int          samples_checked = 0;

   bmf_top #(.DEPTH(DEP)) u_bmf_top (.mclk, .resetn, .full_reset_n, .partial_reset_n, .input_width_select,
      .output_width_select, .width_match_select, .byte_order_select_n, .mode_or_serial_input_pin,
      .async_write_select, .async_read_select, .flag_sync_select, .offset_select, .load_n, .serial_enable_n,
      .wclk, .wen_n, .write_strobe, .data_input_bus, .rclk, .ren_n, .read_strobe, .reread_request_n,
      .output_enable_n, .data_output_bus, .data_output_oe, .empty_or_ready_n, .full_or_space_n,
      .half_full_indicator_n, .almost_empty_indicator_n, .almost_full_indicator_n);

   bmf_host_model u_bmf_host_model (.mclk, .wclk, .wen_n, .write_strobe, .data_input_bus, .rclk, .ren_n,
      .read_strobe, .reread_request_n);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   function automatic logic [35:0] rand36();
      return {4'($urandom), 32'($urandom)};
   endfunction

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (fails == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic settle(input int c);
      repeat (c) @(negedge mclk);
   endtask

   task automatic flags();
      logic [4:0] s;
      s = {empty_or_ready_n, full_or_space_n, half_full_indicator_n, almost_empty_indicator_n, almost_full_indicator_n};
      chk(36'(s), 36'({n != 0, n != DEP, n <= DEP / 2, n > ae_o, n < DEP - af_o}));
   endtask

   // Full reset with configuration pins held; presets picked with load low
   task automatic cfg(input logic [2:0] wsel, input logic be, input logic fw, input logic aw, input logic ar);
      {input_width_select, output_width_select, width_match_select} = wsel;
      byte_order_select_n = be;
      mode_or_serial_input_pin = fw;
      async_write_select = aw;
      async_read_select = ar;
      load_n = 1'b0;
      full_reset_n = 1'b0;
      u_bmf_host_model.set_mode(aw, ar);
      settle(3);
      full_reset_n = 1'b1;
      load_n = 1'b1;
      mode_or_serial_input_pin = 1'b0;
      q.delete();
      n = 0;
      ae_o = 7;
      qo = 36'h0;
      af_o = 7;
      settle(1);
   endtask

   task automatic fill(input int k);
      for (int i = 0; i < k; i++) begin
         d = rand36();
         u_bmf_host_model.wr(d);
         if (n < DEP) begin
            q.push_back(d);
            n++;
         end
         settle(2);
         // Standard timing: a write never changes the bus
         chk(data_output_bus, qo);
         flags();
      end
   endtask

   task automatic drain(input int k, input logic fl);
      for (int i = 0; i < k; i++) begin
         u_bmf_host_model.rc(1'b1, 1'b0);
         settle(2);
         qo = q.pop_front();
         chk(data_output_bus, qo);
         if (fl) begin
            n--;
            flags();
         end
      end
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      results();
   end

   initial begin
      resetn = 1'b0;
      full_reset_n = 1'b1;
      partial_reset_n = 1'b1;
      {input_width_select, output_width_select, width_match_select, byte_order_select_n} = 4'h0;
      {mode_or_serial_input_pin, async_write_select, async_read_select} = 3'h0;
      flag_sync_select = 1'b0;
      offset_select = 2'h0;
      load_n = 1'b1;
      serial_enable_n = 1'b1;
      output_enable_n = 1'b0;
      void'($urandom(17));
      settle(12);
      resetn = 1'b1;
      // Standard 36/36: fill past full, then drain
      cfg(3'b000, 1'b0, 1'b0, 1'b0, 1'b0);
      flags();
      chk(36'(data_output_oe), 36'h1);
      output_enable_n = 1'b1;
      settle(2);
      chk(36'(data_output_oe), 36'h0);
      output_enable_n = 1'b0;
      fill(DEP + 1);
      drain(DEP, 1'b1);
      // Offsets loaded in parallel must survive partial reset
      load_n = 1'b0;
      u_bmf_host_model.wr(36'h2);
      u_bmf_host_model.wr(36'h3);
      load_n = 1'b1;
      ae_o = 2;
      af_o = 3;
      fill(13);
      partial_reset_n = 1'b0;
      settle(2);
      partial_reset_n = 1'b1;
      q.delete();
      n = 0;
      settle(2);
      flags();
      fill(3);
      drain(3, 1'b1);
      // Reread returns to the first location
      cfg(3'b000, 1'b0, 1'b0, 1'b0, 1'b0);
      fill(3);
      w0 = q[0];
      drain(2, 1'b0);
      u_bmf_host_model.rc(1'b0, 1'b1);
      settle(2);
      u_bmf_host_model.rc(1'b1, 1'b0);
      settle(2);
      chk(data_output_bus, w0);
      // Serial offsets; synchronous almost-empty flag moves on read clock rises only
      flag_sync_select = 1'b1;
      cfg(3'b000, 1'b0, 1'b0, 1'b0, 1'b0);
      flag_sync_select = 1'b0;
      load_n = 1'b0;
      serial_enable_n = 1'b0;
      for (int b = 2 * OFS - 1; b >= 0; b--) begin
         mode_or_serial_input_pin = SER[b];
         u_bmf_host_model.wr(36'h0);
      end
      serial_enable_n = 1'b1;
      load_n = 1'b1;
      mode_or_serial_input_pin = 1'b0;
      q.push_back(36'h5);
      q.push_back(36'h6);
      u_bmf_host_model.wr(36'h5);
      u_bmf_host_model.wr(36'h6);
      settle(2);
      chk(36'(almost_empty_indicator_n), 36'h0);
      u_bmf_host_model.rc(1'b0, 1'b0);
      chk(36'(almost_empty_indicator_n), 36'h1);
      drain(2, 1'b0);
      chk(36'(almost_empty_indicator_n), 36'h0);
      // Narrow out and narrow in, both byte orders
      for (int k = 0; k < 8; k++) begin
         p = k[1] ? 4 : 2;
         sw = 36 / p;
         cfg(k[2] ? (k[1] ? 3'b111 : 3'b101) : (k[1] ? 3'b011 : 3'b001), k[0], 1'b0, 1'b0, 1'b0);
         d = rand36();
         if (k[2]) begin
            e = 36'h0;
            for (int j = 0; j < p; j++) begin
               h = (d >> (sw * j)) & ((36'h1 << sw) - 36'h1);
               u_bmf_host_model.wr(h);
               e = e | (h << (sw * (k[0] ? j : p - 1 - j)));
            end
            q.push_back(e);
         end else begin
            u_bmf_host_model.wr(d);
            for (int j = 0; j < p; j++) q.push_back((d >> (sw * (k[0] ? j : p - 1 - j))) & ((36'h1 << sw) - 36'h1));
         end
         settle(2);
         drain(q.size(), 1'b0);
      end
      // Fall-through: first word appears after three read clock rises
      cfg(3'b000, 1'b0, 1'b1, 1'b0, 1'b0);
      d = rand36();
      u_bmf_host_model.wr(d);
      settle(2);
      u_bmf_host_model.rc(1'b0, 1'b0);
      u_bmf_host_model.rc(1'b0, 1'b0);
      chk({34'h0, empty_or_ready_n, full_or_space_n}, 36'h2);
      chk(data_output_bus, 36'h0);
      u_bmf_host_model.rc(1'b0, 1'b0);
      settle(3);
      chk({34'h0, empty_or_ready_n, full_or_space_n}, 36'h0);
      chk(data_output_bus, d);
      e = rand36();
      u_bmf_host_model.wr(e);
      settle(4);
      chk(data_output_bus, d);
      u_bmf_host_model.rc(1'b1, 1'b0);
      settle(2);
      chk(data_output_bus, e);
      // Strobe ports, mode pin high is overridden to standard
      cfg(3'b000, 1'b0, 1'b1, 1'b1, 1'b1);
      fill(2);
      drain(2, 1'b1);
      results();
   end
endmodule
